// ===== rtl/ldc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.svh"
module ldc_regs (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic       CLK_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  output logic      [7:0] RDATA,
  output logic      [4:0] ADC_SEL,
  output logic            ADC_START,
  output logic            FAILSAFE,
  input  wire logic       FAILSAFE_REQ,
  output logic            CLEAR_FAULTS,
  output logic            CLEAR_POWERON,
  output logic            ERR_FLAG_SET,
  input  wire logic       ERR_IN,
  output logic            ERR_OUT,
  output logic            ERR_OE,
  output logic            BRT_PROTECT,
  output logic            CONF_PROTECT,
  output logic            IOUT_PROTECT,
  input  wire logic       BRT_WR_REQ,
  input  wire logic       CONF_WR_REQ,
  input  wire logic       IOUT_WR_REQ,
  output logic            BRT_WR_OK,
  output logic            CONF_WR_OK,
  output logic            IOUT_WR_OK,
  output logic            FULL_RESET,
  output logic            NVM_RELOAD,
  output logic            DEFAULTS_RESTORE,
  output logic            IRQ
);

  // ****************************************
  // Reset release
  // ****************************************
  logic                   rst_s1_q;
  logic                   rst_n_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic                   unlocked_q;
  logic                   soft_reset_q;
  logic                   defaults_q;

  // Strobes are not qualified here; every register below checks CLK_EN
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = WR_EN && (ADDR == ofs);
  endfunction

  logic                   wr_adc;
  logic                   wr_clr;
  logic                   wr_dbg;
  logic                   wr_lock;
  logic                   wr_rest;
  logic                   wr_key;
  logic                   wr_ist;
  logic                   wr_imsk;

  // Gated registers take writes only after the full key
  assign wr_adc  = wr_hit(`LDC_ADC_INPUT_SELECT_OFS);
  assign wr_clr  = wr_hit(`LDC_FAULT_CLEAR_COMMANDS_OFS);
  assign wr_dbg  = wr_hit(`LDC_TEST_FORCE_COMMANDS_OFS) && unlocked_q;
  assign wr_lock = wr_hit(`LDC_WRITE_PROTECT_CONTROL_OFS) && unlocked_q;
  assign wr_rest = wr_hit(`LDC_REGISTER_RESTORE_CMD_OFS) && unlocked_q;
  assign wr_key  = wr_hit(`LDC_CONTROL_ACCESS_KEY_OFS);
  assign wr_ist  = wr_hit(`LDC_IRQ_STATUS_OFS);
  assign wr_imsk = wr_hit(`LDC_IRQ_MASK_OFS);

  // Bank back to its defaults: soft reset or restore of defaults
  logic                   bank_clr;
  assign bank_clr = soft_reset_q || defaults_q;

  // ****************************************
  // ADC input select
  // ****************************************
  logic [4:0]             adc_sel_q;
  logic                   adc_start_q;

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      adc_sel_q   <= `LDC_ADC_SEL_RST;
      adc_start_q <= 1'b0;
    end else if (CLK_EN) begin
      adc_start_q <= wr_adc && !bank_clr;
      if (bank_clr) begin
        adc_sel_q <= `LDC_ADC_SEL_RST;
      end else if (wr_adc) begin
        adc_sel_q <= WDATA[`LDC_ADC_SEL_MSB:0];
      end
    end
  end

  // ****************************************
  // Command pulses
  // ****************************************
  // Commands are one-cycle pulses, so the bits always read back zero
  logic                   leave_failsafe_cmd_q;
  logic                   clear_faults_cmd_q;
  logic                   clear_poweron_flag_cmd_q;
  logic                   enter_failsafe_cmd_q;
  logic                   error_pulse_cmd_q;
  logic                   nvm_reload_cmd_q;

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      leave_failsafe_cmd_q     <= 1'b0;
      clear_faults_cmd_q       <= 1'b0;
      clear_poweron_flag_cmd_q <= 1'b0;
      enter_failsafe_cmd_q     <= 1'b0;
      error_pulse_cmd_q        <= 1'b0;
      soft_reset_q             <= 1'b0;
      nvm_reload_cmd_q         <= 1'b0;
      defaults_q               <= 1'b0;
    end else if (CLK_EN) begin
      leave_failsafe_cmd_q     <= wr_clr && WDATA[`LDC_LEAVE_FAILSAFE_BIT];
      clear_faults_cmd_q       <= wr_clr && WDATA[`LDC_CLEAR_FAULTS_BIT];
      clear_poweron_flag_cmd_q <= wr_clr && WDATA[`LDC_CLEAR_POWERON_BIT];
      enter_failsafe_cmd_q     <= wr_dbg && WDATA[`LDC_ENTER_FAILSAFE_BIT];
      error_pulse_cmd_q        <= wr_dbg && WDATA[`LDC_ERROR_PULSE_BIT];
      soft_reset_q             <= wr_rest && WDATA[`LDC_FULL_RESET_BIT];
      nvm_reload_cmd_q         <= wr_rest && WDATA[`LDC_NVM_RELOAD_BIT];
      defaults_q               <= wr_rest && WDATA[`LDC_DEFAULTS_BIT];
    end
  end

  // ****************************************
  // Operating mode
  // ****************************************
  ldc_pkg::ldc_mode_e     mode_q;
  logic                   fs_req;
  logic                   fs_enter_ev;
  logic                   fs_leave_ev;

  assign fs_req      = enter_failsafe_cmd_q || FAILSAFE_REQ;
  assign fs_enter_ev = (mode_q == ldc_pkg::LDC_NORMAL) && fs_req;
  // A request still standing blocks any leave
  assign fs_leave_ev = (mode_q == ldc_pkg::LDC_FAILSAFE) && !fs_req
                       && (leave_failsafe_cmd_q || soft_reset_q);

  // Entry beats a simultaneous leave: the safe side wins
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= ldc_pkg::LDC_NORMAL;
    end else if (CLK_EN) begin
      case (mode_q)
        ldc_pkg::LDC_NORMAL: begin
          if (enter_failsafe_cmd_q || FAILSAFE_REQ) begin
            mode_q <= ldc_pkg::LDC_FAILSAFE;
          end
        end
        ldc_pkg::LDC_FAILSAFE: begin
          if (fs_leave_ev) begin
            mode_q <= ldc_pkg::LDC_NORMAL;
          end
        end
        default: begin
          mode_q <= ldc_pkg::LDC_NORMAL;
        end
      endcase
    end
  end

  // ****************************************
  // Error pin pulse
  // ****************************************
  localparam ldc_pkg::ldc_cnt_t ERR_CYC = 9'(`LDC_ERR_PULSE_CYC);
  ldc_pkg::ldc_cnt_t      err_cnt_q;
  logic                   err_flag_set_q;
  logic                   err_done_ev;
  logic                   err_busy;

  assign err_done_ev = (err_cnt_q == 9'h001);
  assign err_busy    = (err_cnt_q != 9'h000);

  // Ignored in fail-safe; a new request while running restarts the pulse
  // Soft reset cuts a running pulse short
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      err_cnt_q      <= 9'h000;
      err_flag_set_q <= 1'b0;
    end else if (CLK_EN) begin
      err_flag_set_q <= 1'b0;
      if (soft_reset_q) begin
        err_cnt_q <= 9'h000;
      end else if (error_pulse_cmd_q && mode_q == ldc_pkg::LDC_NORMAL) begin
        err_cnt_q      <= ERR_CYC;
        err_flag_set_q <= 1'b1;
      end else if (err_busy) begin
        err_cnt_q <= err_cnt_q - 9'h001;
      end
    end
  end

  // ****************************************
  // Write protection
  // ****************************************
  logic [2:0]             protect_q;

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      protect_q <= `LDC_PROTECT_RST;
    end else if (CLK_EN) begin
      if (bank_clr) begin
        protect_q <= `LDC_PROTECT_RST;
      end else if (wr_lock) begin
        protect_q <= WDATA[2:0];
      end
    end
  end

  // ****************************************
  // Access key
  // ****************************************
  logic [7:0]             key_q;
  ldc_pkg::ldc_keyidx_t   key_idx_q;

  function automatic logic [7:0] key_byte(input ldc_pkg::ldc_keyidx_t idx);
    case (idx)
      2'h0:    key_byte = `LDC_KEY_0;
      2'h1:    key_byte = `LDC_KEY_1;
      2'h2:    key_byte = `LDC_KEY_2;
      default: key_byte = `LDC_KEY_3;
    endcase
  endfunction

  // Any wrong byte relocks, so a stray write cannot leave the gate open
  // A 43h after unlock starts a new sequence and relocks
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_q      <= `LDC_KEY_RST;
      key_idx_q  <= 2'h0;
      unlocked_q <= 1'b0;
    end else if (CLK_EN) begin
      if (bank_clr) begin
        key_q      <= `LDC_KEY_RST;
        key_idx_q  <= 2'h0;
        unlocked_q <= 1'b0;
      end else if (wr_key) begin
        key_q <= WDATA;
        if (WDATA == key_byte(key_idx_q)) begin
          key_idx_q  <= key_idx_q + 2'h1;
          unlocked_q <= (key_idx_q == 2'h3);
        end else begin
          key_idx_q  <= (WDATA == `LDC_KEY_0) ? 2'h1 : 2'h0;
          unlocked_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [4:0]             irq_st_q;
  logic [4:0]             irq_msk_q;
  logic [4:0]             irq_ev;

  assign irq_ev = {unlocked_q == 1'b0 && wr_key && key_idx_q == 2'h3
                     && WDATA == `LDC_KEY_3,
                   err_done_ev, fs_leave_ev, fs_enter_ev, adc_start_q};

  // A new event wins over a write-one clear in the same cycle
  // Soft reset wipes status and mask; defaults leave them alone
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_st_q  <= `LDC_IRQ_RST;
      irq_msk_q <= `LDC_IRQ_RST;
    end else if (CLK_EN) begin
      if (soft_reset_q) begin
        irq_st_q  <= `LDC_IRQ_RST;
        irq_msk_q <= `LDC_IRQ_RST;
      end else begin
        irq_st_q <= (irq_st_q & ~(wr_ist ? WDATA[4:0] : 5'h00)) | irq_ev;
        if (wr_imsk) begin
          irq_msk_q <= WDATA[4:0];
        end
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [7:0]             rdata_q;
  logic [7:0]             rd_mux;

  always_comb begin
    case (ADDR)
      `LDC_ADC_INPUT_SELECT_OFS:     rd_mux = {3'h0, adc_sel_q};
      `LDC_WRITE_PROTECT_CONTROL_OFS: rd_mux = {5'h00, protect_q};
      `LDC_RESERVED_CONTROL_OFS:     rd_mux = 8'h00;
      `LDC_CONTROL_ACCESS_KEY_OFS:   rd_mux = key_q;
      `LDC_IRQ_STATUS_OFS:           rd_mux = {3'h0, irq_st_q};
      `LDC_IRQ_MASK_OFS:             rd_mux = {3'h0, irq_msk_q};
      default:                       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else if (CLK_EN) begin
      // Zero outside the answer cycle, so stale data never lingers
      rdata_q <= RD_EN ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA            = rdata_q;
  assign ADC_SEL          = adc_sel_q;
  assign ADC_START        = adc_start_q;
  assign FAILSAFE         = (mode_q == ldc_pkg::LDC_FAILSAFE);
  assign CLEAR_FAULTS     = clear_faults_cmd_q;
  assign CLEAR_POWERON    = clear_poweron_flag_cmd_q;
  assign ERR_FLAG_SET     = err_flag_set_q;
  // Open drain: only ever pulls low
  assign ERR_OUT          = 1'b0;
  assign ERR_OE           = err_busy;
  assign BRT_PROTECT      = protect_q[`LDC_BRIGHTNESS_PROT_BIT];
  assign CONF_PROTECT     = protect_q[`LDC_CONFIG_PROT_BIT];
  assign IOUT_PROTECT     = protect_q[`LDC_CURRENT_PROT_BIT];
  assign BRT_WR_OK        = BRT_WR_REQ && !protect_q[`LDC_BRIGHTNESS_PROT_BIT];
  assign CONF_WR_OK       = CONF_WR_REQ && !protect_q[`LDC_CONFIG_PROT_BIT];
  assign IOUT_WR_OK       = IOUT_WR_REQ && !protect_q[`LDC_CURRENT_PROT_BIT];
  assign FULL_RESET       = soft_reset_q;
  assign NVM_RELOAD       = nvm_reload_cmd_q;
  assign DEFAULTS_RESTORE = defaults_q;
  assign IRQ              = |(irq_st_q & irq_msk_q);

  // ERR_IN is the shared wire level; kept for system use, not needed here
  logic                   err_in_unused;
  assign err_in_unused = ERR_IN;

endmodule
`default_nettype wire

// ===== rtl/ldc_map.svh
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define LDC_ADC_INPUT_SELECT_OFS      8'h90
`define LDC_FAULT_CLEAR_COMMANDS_OFS  8'h91
`define LDC_TEST_FORCE_COMMANDS_OFS   8'h92
`define LDC_WRITE_PROTECT_CONTROL_OFS 8'h93
`define LDC_REGISTER_RESTORE_CMD_OFS  8'h94
`define LDC_RESERVED_CONTROL_OFS      8'h95
`define LDC_CONTROL_ACCESS_KEY_OFS    8'h96
`define LDC_IRQ_STATUS_OFS            8'h9a
`define LDC_IRQ_MASK_OFS              8'h9b
// ****************************************
// Field positions
// ****************************************
`define LDC_ADC_SEL_MSB          4
`define LDC_LEAVE_FAILSAFE_BIT   2
`define LDC_CLEAR_FAULTS_BIT     1
`define LDC_CLEAR_POWERON_BIT    0
`define LDC_ENTER_FAILSAFE_BIT   1
`define LDC_ERROR_PULSE_BIT      0
`define LDC_BRIGHTNESS_PROT_BIT  2
`define LDC_CONFIG_PROT_BIT      1
`define LDC_CURRENT_PROT_BIT     0
`define LDC_FULL_RESET_BIT       2
`define LDC_NVM_RELOAD_BIT       1
`define LDC_DEFAULTS_BIT         0
`define LDC_IRQ_ADC_START_BIT    0
`define LDC_IRQ_FS_ENTER_BIT     1
`define LDC_IRQ_FS_LEAVE_BIT     2
`define LDC_IRQ_ERR_DONE_BIT     3
`define LDC_IRQ_UNLOCK_BIT       4
// ****************************************
// Reset values
// ****************************************
`define LDC_ADC_SEL_RST          5'h00
`define LDC_PROTECT_RST          3'h3
`define LDC_KEY_RST              8'h00
`define LDC_IRQ_RST              5'h00
// ****************************************
// Access key sequence
// ****************************************
`define LDC_KEY_0                8'h43
`define LDC_KEY_1                8'h4f
`define LDC_KEY_2                8'h44
`define LDC_KEY_3                8'h45
// ****************************************
// Timing
// ****************************************
`define LDC_CLK_PERIOD_NS        100
`define LDC_ERR_PULSE_NS         50000
`define LDC_ERR_PULSE_CYC        (`LDC_ERR_PULSE_NS / `LDC_CLK_PERIOD_NS)
`endif

// ===== rtl/ldc_pkg.sv
package ldc_pkg;
  typedef enum logic {LDC_NORMAL, LDC_FAILSAFE} ldc_mode_e;
  typedef logic [8:0] ldc_cnt_t;
  typedef logic [1:0] ldc_keyidx_t;
endpackage

// ===== bench/ldc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the control bank
// ****************************************
module ldc_regs_checker (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic       CLK_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] RDATA,
  input wire logic [4:0] ADC_SEL,
  input wire logic       ADC_START,
  input wire logic       FAILSAFE,
  input wire logic       FAILSAFE_REQ,
  input wire logic       CLEAR_FAULTS,
  input wire logic       CLEAR_POWERON,
  input wire logic       ERR_FLAG_SET,
  input wire logic       ERR_OUT,
  input wire logic       ERR_OE,
  input wire logic       BRT_PROTECT,
  input wire logic       CONF_PROTECT,
  input wire logic       IOUT_PROTECT,
  input wire logic       BRT_WR_REQ,
  input wire logic       CONF_WR_REQ,
  input wire logic       IOUT_WR_REQ,
  input wire logic       BRT_WR_OK,
  input wire logic       CONF_WR_OK,
  input wire logic       IOUT_WR_OK
);
  // Pulse length counter; too long for a repetition
  logic [9:0] oe_cnt_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      oe_cnt_q <= 10'h000;
    end else begin
      oe_cnt_q <= ERR_OE ? oe_cnt_q + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_adc_wr;
    WR_EN && CLK_EN && ADDR == 8'h90;
  endsequence
  sequence s_leave;
    WR_EN && CLK_EN && ADDR == 8'h91 && WDATA[2] && !FAILSAFE_REQ ##1 !FAILSAFE_REQ;
  endsequence
  a_adc_start: assert property (s_adc_wr |=> ADC_START && ADC_SEL == $past(WDATA[4:0]))
    else $error("adc start or select wrong");
  a_start_cause: assert property (ADC_START |-> $past(WR_EN && ADDR == 8'h90))
    else $error("adc start without write");
  a_clear_pulses: assert property (WR_EN && CLK_EN && ADDR == 8'h91 |=>
    CLEAR_FAULTS == $past(WDATA[1]) && CLEAR_POWERON == $past(WDATA[0]))
    else $error("clear pulses wrong");
  a_cmd_reads_zero: assert property (RD_EN && CLK_EN && (ADDR == 8'h91 || ADDR == 8'h92
    || ADDR == 8'h94 || ADDR == 8'h95) |=> RDATA == 8'h00)
    else $error("command register read nonzero");
  a_fs_request: assert property (FAILSAFE_REQ && CLK_EN |=> FAILSAFE)
    else $error("fail-safe not entered");
  a_fs_leave: assert property (s_leave |=> !FAILSAFE)
    else $error("fail-safe not left");
  a_err_start: assert property ($rose(ERR_OE) |-> ERR_FLAG_SET)
    else $error("error pulse without flag");
  a_err_len: assert property ($fell(ERR_OE) |-> oe_cnt_q == 10'h1f4)
    else $error("error pulse length wrong");
  a_err_pin_low: assert property (ERR_OUT == 1'b0)
    else $error("error pin driven high");
  a_wr_gating: assert property ((BRT_WR_OK == (BRT_WR_REQ && !BRT_PROTECT))
    && (CONF_WR_OK == (CONF_WR_REQ && !CONF_PROTECT))
    && (IOUT_WR_OK == (IOUT_WR_REQ && !IOUT_PROTECT)))
    else $error("protected group write passed");
endmodule
bind ldc_regs ldc_regs_checker u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .ADC_SEL(ADC_SEL), .ADC_START(ADC_START),
  .FAILSAFE(FAILSAFE), .FAILSAFE_REQ(FAILSAFE_REQ), .CLEAR_FAULTS(CLEAR_FAULTS),
  .CLEAR_POWERON(CLEAR_POWERON), .ERR_FLAG_SET(ERR_FLAG_SET), .ERR_OUT(ERR_OUT),
  .ERR_OE(ERR_OE), .BRT_PROTECT(BRT_PROTECT), .CONF_PROTECT(CONF_PROTECT),
  .IOUT_PROTECT(IOUT_PROTECT), .BRT_WR_REQ(BRT_WR_REQ), .CONF_WR_REQ(CONF_WR_REQ),
  .IOUT_WR_REQ(IOUT_WR_REQ), .BRT_WR_OK(BRT_WR_OK), .CONF_WR_OK(CONF_WR_OK),
  .IOUT_WR_OK(IOUT_WR_OK)
);
`default_nettype wire

// ===== bench/ldc_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.svh"
module ldc_regs_test;
  logic       CLK_SYS = 1'b0;
  logic       RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR_EN = 1'b0;
  logic       RD_EN = 1'b0;
  logic       FAILSAFE_REQ = 1'b0;
  logic       CLK_EN = 1'b1;
  logic [2:0] req = 3'h0;
  logic [7:0] RDATA;
  logic [4:0] ADC_SEL;
  logic       ADC_START, FAILSAFE, CLEAR_FAULTS, CLEAR_POWERON, ERR_FLAG_SET, ERR_OUT;
  logic       ERR_OE, BRT_PROTECT, CONF_PROTECT, IOUT_PROTECT, BRT_WR_OK, CONF_WR_OK;
  logic       IOUT_WR_OK, FULL_RESET, NVM_RELOAD, DEFAULTS_RESTORE, IRQ;
  logic [7:0] pulses, levels, oks;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         n;
  assign pulses = {1'b0, ADC_START, CLEAR_FAULTS, CLEAR_POWERON, ERR_FLAG_SET,
                   FULL_RESET, NVM_RELOAD, DEFAULTS_RESTORE};
  assign levels = {1'b0, FAILSAFE, ERR_OE, BRT_PROTECT, CONF_PROTECT, IOUT_PROTECT,
                   IRQ, ERR_OUT};
  assign oks = {5'h00, BRT_WR_OK, CONF_WR_OK, IOUT_WR_OK};
  always #50 CLK_SYS = ~CLK_SYS;
  // Error pin input tied: pin idle high
  ldc_regs u_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .ADC_SEL(ADC_SEL), .ADC_START(ADC_START),
    .FAILSAFE(FAILSAFE), .FAILSAFE_REQ(FAILSAFE_REQ), .CLEAR_FAULTS(CLEAR_FAULTS),
    .CLEAR_POWERON(CLEAR_POWERON), .ERR_FLAG_SET(ERR_FLAG_SET), .ERR_IN(1'b1),
    .ERR_OUT(ERR_OUT), .ERR_OE(ERR_OE), .BRT_PROTECT(BRT_PROTECT),
    .CONF_PROTECT(CONF_PROTECT), .IOUT_PROTECT(IOUT_PROTECT), .BRT_WR_REQ(req[2]),
    .CONF_WR_REQ(req[1]), .IOUT_WR_REQ(req[0]), .BRT_WR_OK(BRT_WR_OK),
    .CONF_WR_OK(CONF_WR_OK), .IOUT_WR_OK(IOUT_WR_OK), .FULL_RESET(FULL_RESET),
    .NVM_RELOAD(NVM_RELOAD), .DEFAULTS_RESTORE(DEFAULTS_RESTORE), .IRQ(IRQ)
  );
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLK_SYS);
    WR_EN <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLK_SYS);
    RD_EN <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask
  task automatic key(input logic [7:0] last);
    wr(8'h96, 8'h43);
    wr(8'h96, 8'h4f);
    wr(8'h96, 8'h44);
    wr(8'h96, last);
  endtask
  task automatic set_req(input logic [2:0] r);
    @(posedge CLK_SYS);
    req <= r;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d compares=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    tick(3);
    chk(levels, 8'h0c);
    rd(8'h93, 8'h03);
    rd(8'h96, 8'h00);
    set_req(3'h7);
    chk(oks, 8'h04);
    wr(8'h90, 8'hff);
    chk(pulses, 8'h40);
    chk({3'h0, ADC_SEL}, 8'h1f);
    rd(8'h90, 8'h1f);
    @(posedge CLK_SYS);
    CLK_EN <= 1'b0;
    wr(8'h90, 8'h0a);
    chk({3'h0, ADC_SEL}, 8'h1f);
    chk(pulses, 8'h00);
    @(posedge CLK_SYS);
    CLK_EN <= 1'b1;
    wr(8'h95, 8'hff);
    rd(8'h95, 8'h00);
    rd(8'h80, 8'h00);
    wr(8'h93, 8'h00);
    rd(8'h93, 8'h03);
    key(8'h00);
    wr(8'h93, 8'h00);
    rd(8'h93, 8'h03);
    key(8'h45);
    wr(8'h93, 8'h04);
    rd(8'h93, 8'h04);
    chk(oks, 8'h03);
    wr(8'h91, 8'h03);
    chk(pulses, 8'h30);
    wr(8'h91, 8'h01);
    chk(pulses, 8'h10);
    rd(8'h91, 8'h00);
    wr(8'h9b, 8'h00);
    wr(8'h90, 8'h03);
    tick(2);
    chk(levels, 8'h10);
    wr(8'h9b, 8'h01);
    tick(1);
    chk(levels, 8'h12);
    rd(8'h9a, 8'h11);
    wr(8'h9a, 8'hff);
    wr(8'h9b, 8'h00);
    tick(1);
    chk(levels, 8'h10);
    wr(8'h92, 8'h02);
    tick(1);
    chk(levels, 8'h50);
    rd(8'h92, 8'h00);
    wr(8'h92, 8'h01);
    tick(1);
    chk(levels, 8'h50);
    wr(8'h91, 8'h04);
    tick(1);
    chk(levels, 8'h10);
    @(posedge CLK_SYS);
    FAILSAFE_REQ <= 1'b1;
    @(posedge CLK_SYS);
    FAILSAFE_REQ <= 1'b0;
    #1;
    chk(levels, 8'h50);
    wr(8'h91, 8'h04);
    tick(1);
    chk(levels, 8'h10);
    wr(8'h92, 8'h01);
    tick(1);
    chk(pulses, 8'h08);
    chk(levels, 8'h30);
    n = 0;
    while (ERR_OE === 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    samples_checked++;
    if (n != `LDC_ERR_PULSE_CYC) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, `LDC_ERR_PULSE_CYC);
    end
    wr(8'h93, 8'h07);
    wr(8'h94, 8'h01);
    chk(pulses, 8'h01);
    tick(1);
    chk(levels, 8'h0c);
    rd(8'h90, 8'h00);
    wr(8'h93, 8'h00);
    rd(8'h93, 8'h03);
    key(8'h45);
    wr(8'h94, 8'h02);
    chk(pulses, 8'h02);
    rd(8'h94, 8'h00);
    wr(8'h9b, 8'h02);
    wr(8'h92, 8'h02);
    tick(1);
    chk(levels, 8'h4e);
    rd(8'h9a, 8'h1e);
    wr(8'h94, 8'h04);
    chk(pulses, 8'h04);
    tick(1);
    chk(levels, 8'h0c);
    rd(8'h9b, 8'h00);
    wr(8'h90, 8'h05);
    chk({3'h0, ADC_SEL}, 8'h05);
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    tick(3);
    chk(levels, 8'h0c);
    rd(8'h90, 8'h00);
    rd(8'h9a, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
